// ==== option_byte_config_decoder.sv ====
// option byte capture, decode, protected erase sequence and avalon register slave
// Operation
// - package bits select 64, 44 or 32 pins
// - unbonded pads pulled up, configuration locked
// - protect bit zero enables read-out protection
// - protection blocks extraction and flash writes
// - protected option erase wipes user memory first
// - remap high zero: timer on port D
// - remap low bit moves capture2 PD1 to PC1
// - clock source type from second byte 5:4
// - oscillator range from second byte 3:2
// - delay 4096 or 256 cycles, reset/halt exit
//
// Decided for this implementation: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`include "option_byte_map.svh"

module option_byte_config_decoder
#(
  parameter int LONG_CYCLES  = `RST_DELAY_LONG,
  parameter int SHORT_CYCLES = `RST_DELAY_SHORT
)
(
  // clock and reset
  input  wire logic                                i_clk,
  input  wire logic                                i_reset,
  // non-volatile option bytes
  input  wire logic [7:0]                          i_opt_byte0,
  input  wire logic [7:0]                          i_opt_byte1,
  // cpu halt exit and flash erase handshake
  input  wire logic                                i_halt_exit,
  input  wire logic                                i_user_erase_done,
  input  wire logic                                i_opt_erase_done,
  // avalon-mm slave
  input  wire logic [3:0]                          i_avs_address,
  input  wire logic                                i_avs_read,
  input  wire logic                                i_avs_write,
  input  wire logic [31:0]                         i_avs_writedata,
  input  wire logic [3:0]                          i_avs_byteenable,
  output logic [31:0]                              o_avs_readdata,
  output logic                                     o_avs_waitrequest,
  // decoded settings
  output option_byte_pkg::package_select_t         o_package_select,
  output logic                                     o_readout_protect,
  output option_byte_pkg::clock_source_type_t      o_clock_source_type,
  output option_byte_pkg::oscillator_range_t       o_oscillator_range,
  output logic                                     o_reset_delay_select,
  // pad control
  output logic                                     o_pullup_lock_grp44,
  output logic                                     o_pullup_lock_grp64,
  output logic                                     o_extract_block,
  output logic                                     o_flash_write_block,
  // alternate function routing
  output option_byte_pkg::pin_t                    o_timer_compare_out1_pin,
  output option_byte_pkg::pin_t                    o_timer_compare_out2_pin,
  output option_byte_pkg::pin_t                    o_timer_capture_in1_pin,
  output option_byte_pkg::pin_t                    o_timer_capture_in2_pin,
  output option_byte_pkg::pin_t                    o_serial2_clock_pin,
  output option_byte_pkg::pin_t                    o_serial2_tx_pin,
  output option_byte_pkg::pin_t                    o_serial2_rx_pin,
  output logic                                     o_serial2_enable,
  // erase and cpu control
  output logic                                     o_user_erase_req,
  output logic                                     o_opt_erase_req,
  output logic                                     o_cpu_hold
);
  import option_byte_pkg::*;

  decoder_state_t s_r;
  decoder_state_t s_nxt;

  logic       dly_busy;
  logic [7:0] b0;
  logic [7:0] b1;
  logic       remap_hi;
  logic       remap_lo;
  logic       req;
  logic       wr_acc;
  logic       wr_ctrl;
  logic       erase_cmd;
  logic       halt_cmd;

  function automatic package_select_t decode_package(input logic [1:0] bits);
    if (bits[1])
      return PKG_64;
    else if (bits[0])
      return PKG_44;
    else
      return PKG_32;
  endfunction : decode_package

  function automatic pin_t pick_pin(input logic sel, input pin_t when0, input pin_t when1);
    return sel ? when1 : when0;
  endfunction : pick_pin

  function automatic logic is_loaded(input load_state_t st);
    return st == LD_DONE;
  endfunction : is_loaded

  // synchronised option bytes
  assign b0       = s_r.sync0_b;
  assign b1       = s_r.sync1_b;
  assign remap_hi = b1[`OPT1_MAP_HI];
  assign remap_lo = b1[`OPT1_MAP_LO];

  // register access decode
  assign req       = i_avs_read | i_avs_write;
  // a write acts only at the edge that ends the ready cycle
  assign wr_acc    = i_avs_write & ~s_r.waitreq;
  assign wr_ctrl   = wr_acc & (i_avs_address == `REG_CONTROL) & i_avs_byteenable[0];
  assign erase_cmd = wr_ctrl & i_avs_writedata[`CTRL_ERASE_BIT];
  assign halt_cmd  = i_halt_exit | (wr_ctrl & i_avs_writedata[`CTRL_HALT_EXIT_BIT]);

  reset_delay_counter
  #(
    .LONG_CYCLES  (LONG_CYCLES),
    .SHORT_CYCLES (SHORT_CYCLES)
  )
  u_delay
  (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_start (s_r.dly_start),
    .i_short (s_r.short_dly),
    .o_busy  (dly_busy)
  );

  always_comb
  begin
    s_nxt           = s_r;
    s_nxt.sync0_a   = i_opt_byte0;
    s_nxt.sync0_b   = s_r.sync0_a;
    s_nxt.sync1_a   = i_opt_byte1;
    s_nxt.sync1_b   = s_r.sync1_a;
    s_nxt.dly_start = 1'b0;

    // option byte load, once per reset
    case (s_r.ld)
      LD_WAIT0:
        s_nxt.ld = LD_WAIT1;
      LD_WAIT1:
        s_nxt.ld = LD_CAPTURE;
      LD_CAPTURE:
      begin
        s_nxt.opt0      = b0;
        s_nxt.opt1      = b1;
        s_nxt.pkg       = decode_package(b0[`OPT0_PKG_HI:`OPT0_PKG_LO]);
        s_nxt.protect   = ~b0[`OPT0_PROTECT_BIT];
        s_nxt.clk_src   = clock_source_type_t'(b1[`OPT1_TYPE_HI:`OPT1_TYPE_LO]);
        s_nxt.range     = oscillator_range_t'(b1[`OPT1_RANGE_HI:`OPT1_RANGE_LO]);
        s_nxt.short_dly = b1[`OPT1_RSTDLY_BIT];
        s_nxt.cmp1      = pick_pin(remap_hi, PIN_PD3, PIN_PB6);
        s_nxt.cmp2      = pick_pin(remap_hi, PIN_PD5, PIN_PB7);
        s_nxt.cap1      = pick_pin(remap_hi, PIN_PD4, PIN_PC0);
        s_nxt.s2_clk    = pick_pin(remap_hi, PIN_NONE, PIN_PD3);
        s_nxt.s2_tx     = pick_pin(remap_hi, PIN_NONE, PIN_PD5);
        s_nxt.s2_rx     = pick_pin(remap_hi, PIN_NONE, PIN_PD4);
        s_nxt.s2_en     = remap_hi;
        s_nxt.cap2      = pick_pin(remap_lo, PIN_PD1, PIN_PC1);
        s_nxt.dly_start = 1'b1;
        s_nxt.ld        = LD_DONE;
      end
      LD_DONE:
      begin
        s_nxt.ld = LD_DONE;
        // a halt exit while a delay runs is dropped, not queued
        if (halt_cmd && !dly_busy && !s_r.dly_start)
          s_nxt.dly_start = 1'b1;
      end
      default:
        s_nxt.ld = LD_WAIT0;
    endcase

    // unbonded pads: 32 pins leaves both groups open, 44 leaves the 64-only group
    s_nxt.lock44 = 1'b0;
    s_nxt.lock64 = 1'b0;
    if (is_loaded(s_nxt.ld))
    begin
      case (s_nxt.pkg)
        PKG_32:
        begin
          s_nxt.lock44 = 1'b1;
          s_nxt.lock64 = 1'b1;
        end
        PKG_44:
          s_nxt.lock64 = 1'b1;
        default:
          s_nxt.lock64 = 1'b0;
      endcase
    end

    // option erase: user memory goes first when protected
    case (s_r.er)
      ER_IDLE:
      begin
        if (erase_cmd && is_loaded(s_r.ld))
        begin
          if (s_r.protect)
          begin
            s_nxt.er             = ER_USER;
            s_nxt.user_erase_req = 1'b1;
          end
          else
          begin
            s_nxt.er            = ER_OPT;
            s_nxt.opt_erase_req = 1'b1;
          end
        end
      end
      ER_USER:
      begin
        if (i_user_erase_done)
        begin
          s_nxt.user_erase_req = 1'b0;
          s_nxt.opt_erase_req  = 1'b1;
          s_nxt.er             = ER_OPT;
        end
      end
      ER_OPT:
      begin
        if (i_opt_erase_done)
        begin
          s_nxt.opt_erase_req = 1'b0;
          s_nxt.erased        = 1'b1;
          s_nxt.er            = ER_DONE;
        end
      end
      ER_DONE:
        s_nxt.er = ER_IDLE;
      default:
      begin
        s_nxt.er             = ER_IDLE;
        s_nxt.user_erase_req = 1'b0;
        s_nxt.opt_erase_req  = 1'b0;
      end
    endcase

    // blocked until loaded; lifted once protected contents are gone
    s_nxt.block = !is_loaded(s_nxt.ld) || (s_nxt.protect && !s_nxt.erased);

    // hold spans the start pulse and the counter's own register stage
    s_nxt.cpu_hold = !is_loaded(s_nxt.ld) || s_nxt.dly_start || s_r.dly_start ||
                     dly_busy;

    // one wait cycle, then a single ready cycle
    s_nxt.waitreq = ~(req & s_r.waitreq);
    // read data loads in the wait cycle, so it stands at the accept edge
    if (i_avs_read && s_r.waitreq)
    begin
      case (i_avs_address)
        `REG_OPT_RAW:
          s_nxt.rdata = {15'h0000, is_loaded(s_r.ld), s_r.opt1, s_r.opt0};
        `REG_DECODE:
          s_nxt.rdata = {7'h00, s_r.s2_en, s_r.cap2, s_r.cap1, s_r.cmp2, s_r.cmp1,
                         s_r.short_dly, s_r.range, s_r.clk_src, s_r.protect, s_r.pkg};
        `REG_STATUS:
          s_nxt.rdata = {26'h0000000, dly_busy, s_r.cpu_hold, s_r.erased, s_r.er};
        default:
          s_nxt.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      s_r          <= '0;
      s_r.block    <= 1'b1;
      s_r.cpu_hold <= 1'b1;
      s_r.waitreq  <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign o_avs_readdata           = s_r.rdata;
  assign o_avs_waitrequest        = s_r.waitreq;
  assign o_package_select         = s_r.pkg;
  assign o_readout_protect        = s_r.protect;
  assign o_clock_source_type      = s_r.clk_src;
  assign o_oscillator_range       = s_r.range;
  assign o_reset_delay_select     = s_r.short_dly;
  assign o_pullup_lock_grp44      = s_r.lock44;
  assign o_pullup_lock_grp64      = s_r.lock64;
  assign o_extract_block          = s_r.block;
  assign o_flash_write_block      = s_r.block;
  assign o_timer_compare_out1_pin = s_r.cmp1;
  assign o_timer_compare_out2_pin = s_r.cmp2;
  assign o_timer_capture_in1_pin  = s_r.cap1;
  assign o_timer_capture_in2_pin  = s_r.cap2;
  assign o_serial2_clock_pin      = s_r.s2_clk;
  assign o_serial2_tx_pin         = s_r.s2_tx;
  assign o_serial2_rx_pin         = s_r.s2_rx;
  assign o_serial2_enable         = s_r.s2_en;
  assign o_user_erase_req         = s_r.user_erase_req;
  assign o_opt_erase_req          = s_r.opt_erase_req;
  assign o_cpu_hold               = s_r.cpu_hold;

endmodule : option_byte_config_decoder

// ==== option_byte_map.svh ====
// field positions, register offsets, control bits and delay counts of the option byte decoder
`ifndef OPTION_BYTE_MAP_SVH
`define OPTION_BYTE_MAP_SVH

// first option byte
`define OPT0_PKG_HI        2
`define OPT0_PKG_LO        1
`define OPT0_PROTECT_BIT   0

// second option byte
`define OPT1_MAP_HI        7
`define OPT1_MAP_LO        6
`define OPT1_TYPE_HI       5
`define OPT1_TYPE_LO       4
`define OPT1_RANGE_HI      3
`define OPT1_RANGE_LO      2
`define OPT1_RSTDLY_BIT    0

// register byte offsets
`define REG_OPT_RAW        4'h0
`define REG_DECODE         4'h4
`define REG_CONTROL        4'h8
`define REG_STATUS         4'hC

// control register bits
`define CTRL_ERASE_BIT     0
`define CTRL_HALT_EXIT_BIT 1

// reset / halt-exit delay in cpu cycles
`define RST_DELAY_LONG     4096
`define RST_DELAY_SHORT    256
`define DLY_CNT_W          13

`endif

// ==== option_byte_pkg.sv ====
// types shared by the option byte decoder modules
`include "option_byte_map.svh"

package option_byte_pkg;

  typedef enum logic [1:0] {
    PKG_32 = 2'b00,
    PKG_44 = 2'b01,
    PKG_64 = 2'b10
  } package_select_t;

  typedef enum logic [1:0] {
    CLK_RESONATOR = 2'b00,
    CLK_RESERVED  = 2'b01,
    CLK_INTERNAL  = 2'b10,
    CLK_EXTERNAL  = 2'b11
  } clock_source_type_t;

  typedef enum logic [1:0] {
    RANGE_1_2MHZ  = 2'b00,
    RANGE_2_4MHZ  = 2'b01,
    RANGE_4_8MHZ  = 2'b10,
    RANGE_8_16MHZ = 2'b11
  } oscillator_range_t;

  typedef enum logic [3:0] {
    PIN_NONE = 4'h0,
    PIN_PD1  = 4'h1,
    PIN_PD3  = 4'h2,
    PIN_PD4  = 4'h3,
    PIN_PD5  = 4'h4,
    PIN_PB6  = 4'h5,
    PIN_PB7  = 4'h6,
    PIN_PC0  = 4'h7,
    PIN_PC1  = 4'h8
  } pin_t;

  typedef enum logic [1:0] {
    LD_WAIT0   = 2'b00,
    LD_WAIT1   = 2'b01,
    LD_CAPTURE = 2'b10,
    LD_DONE    = 2'b11
  } load_state_t;

  typedef enum logic [2:0] {
    ER_IDLE = 3'b000,
    ER_USER = 3'b001,
    ER_OPT  = 3'b010,
    ER_DONE = 3'b011
  } erase_state_t;

  typedef struct packed {
    logic                 busy;
    logic [`DLY_CNT_W-1:0] cnt;
  } delay_state_t;

  typedef struct packed {
    logic [7:0]         sync0_a;
    logic [7:0]         sync0_b;
    logic [7:0]         sync1_a;
    logic [7:0]         sync1_b;
    load_state_t        ld;
    logic [7:0]         opt0;
    logic [7:0]         opt1;
    package_select_t    pkg;
    logic               protect;
    logic               short_dly;
    clock_source_type_t clk_src;
    oscillator_range_t  range;
    pin_t               cmp1;
    pin_t               cmp2;
    pin_t               cap1;
    pin_t               cap2;
    pin_t               s2_clk;
    pin_t               s2_tx;
    pin_t               s2_rx;
    logic               s2_en;
    logic               lock44;
    logic               lock64;
    erase_state_t       er;
    logic               user_erase_req;
    logic               opt_erase_req;
    logic               erased;
    logic               block;
    logic               dly_start;
    logic               cpu_hold;
    logic               waitreq;
    logic [31:0]        rdata;
  } decoder_state_t;

endpackage : option_byte_pkg

// ==== reset_delay_counter.sv ====
// counter that holds busy for the selected number of cpu cycles
`timescale 1ns/1ps
`include "option_byte_map.svh"

module reset_delay_counter
#(
  parameter int LONG_CYCLES  = `RST_DELAY_LONG,
  parameter int SHORT_CYCLES = `RST_DELAY_SHORT
)
(
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_reset,
  // control
  input  wire logic i_start,
  input  wire logic i_short,
  // status
  output logic      o_busy
);
  import option_byte_pkg::*;

  delay_state_t s_r;
  delay_state_t s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    if (i_start)
    begin
      s_nxt.busy = 1'b1;
      s_nxt.cnt  = i_short ? `DLY_CNT_W'(SHORT_CYCLES - 1)
                           : `DLY_CNT_W'(LONG_CYCLES - 1);
    end
    else if (s_r.busy)
    begin
      if (s_r.cnt == '0)
        s_nxt.busy = 1'b0;
      else
        s_nxt.cnt = s_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign o_busy = s_r.busy;

endmodule : reset_delay_counter

// ==== option_byte_config_decoder_props.sv ====
// port assertions for the option byte decoder
`timescale 1ns/1ps

module option_byte_config_decoder_props
#(
  parameter int LONG_CYCLES  = 4096,
  parameter int SHORT_CYCLES = 256
)
(
  // clock and reset
  input  wire logic                                i_clk,
  input  wire logic                                i_reset,
  // inputs watched
  input  wire logic [7:0]                          i_opt_byte0,
  input  wire logic [7:0]                          i_opt_byte1,
  input  wire logic                                i_halt_exit,
  input  wire logic                                i_avs_read,
  input  wire logic                                i_avs_write,
  // outputs watched
  input  wire logic                                o_avs_waitrequest,
  input  wire option_byte_pkg::package_select_t    o_package_select,
  input  wire logic                                o_readout_protect,
  input  wire option_byte_pkg::clock_source_type_t o_clock_source_type,
  input  wire option_byte_pkg::oscillator_range_t  o_oscillator_range,
  input  wire logic                                o_reset_delay_select,
  input  wire logic                                o_pullup_lock_grp44,
  input  wire logic                                o_pullup_lock_grp64,
  input  wire logic                                o_extract_block,
  input  wire logic                                o_flash_write_block,
  input  wire option_byte_pkg::pin_t               o_timer_compare_out1_pin,
  input  wire option_byte_pkg::pin_t               o_timer_compare_out2_pin,
  input  wire option_byte_pkg::pin_t               o_timer_capture_in1_pin,
  input  wire option_byte_pkg::pin_t               o_timer_capture_in2_pin,
  input  wire option_byte_pkg::pin_t               o_serial2_clock_pin,
  input  wire logic                                o_user_erase_req,
  input  wire logic                                o_opt_erase_req,
  input  wire logic                                o_cpu_hold
);
  import option_byte_pkg::*;
  logic [2:0]  cyc_r;
  logic [7:0]  s0_r;
  logic [7:0]  s1_r;
  logic [15:0] hcnt_r;
  int          dly;
  assign dly = s1_r[0] ? SHORT_CYCLES : LONG_CYCLES;
  // snapshot of the bytes as they stood just after reset
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      cyc_r  <= 3'h0;
      hcnt_r <= 16'h0000;
    end
    else
    begin
      hcnt_r <= o_cpu_hold ? hcnt_r + 16'h0001 : 16'h0000;
      if (cyc_r != 3'h7)
        cyc_r <= cyc_r + 3'h1;
      if (cyc_r < 3'h3)
      begin
        s0_r <= i_opt_byte0;
        s1_r <= i_opt_byte1;
      end
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  pkg_decode_a: assert property (cyc_r == 3'h7 |-> o_package_select ==
    (s0_r[2] ? PKG_64 : (s0_r[1] ? PKG_44 : PKG_32))) else $error("package decode wrong");
  pullup_lock_a: assert property (cyc_r == 3'h7 |-> o_pullup_lock_grp44 ==
    (s0_r[2:1] == 2'h0) && o_pullup_lock_grp64 == !s0_r[2]) else $error("pullup lock wrong");
  protect_sel_a: assert property (cyc_r == 3'h7 |-> o_readout_protect == !s0_r[0])
    else $error("protect decode wrong");
  unprot_open_a: assert property (cyc_r == 3'h7 && s0_r[0] |->
    !o_extract_block && !o_flash_write_block) else $error("block while unprotected");
  remap_hi_a: assert property (cyc_r == 3'h7 |-> o_timer_compare_out1_pin ==
    (s1_r[7] ? PIN_PB6 : PIN_PD3) && o_timer_compare_out2_pin == (s1_r[7] ? PIN_PB7 : PIN_PD5)
    && o_timer_capture_in1_pin == (s1_r[7] ? PIN_PC0 : PIN_PD4)
    && o_serial2_clock_pin == (s1_r[7] ? PIN_PD3 : PIN_NONE)) else $error("remap high wrong");
  remap_lo_a: assert property (cyc_r == 3'h7 |-> o_timer_capture_in2_pin ==
    (s1_r[6] ? PIN_PC1 : PIN_PD1)) else $error("capture2 remap wrong");
  clock_fields_a: assert property (cyc_r == 3'h7 |->
    o_clock_source_type == s1_r[5:4] && o_oscillator_range == s1_r[3:2]
    && o_reset_delay_select == s1_r[0]) else $error("clock fields wrong");
  hold_len_a: assert property ($fell(o_cpu_hold) |-> hcnt_r >= dly && hcnt_r <= dly + 10)
    else $error("delay length wrong");
  halt_hold_a: assert property (i_halt_exit && !o_cpu_hold |-> ##[1:3] o_cpu_hold)
    else $error("halt exit gave no delay");
  erase_order_a: assert property (o_user_erase_req |-> !o_opt_erase_req)
    else $error("option erase before user erase");
  erase_chain_a: assert property ($fell(o_user_erase_req) |-> o_opt_erase_req)
    else $error("option erase did not follow");
  bus_answer_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest ##1 o_avs_waitrequest) else $error("bus answer timing wrong");
endmodule : option_byte_config_decoder_props

bind option_byte_config_decoder option_byte_config_decoder_props
  #(.LONG_CYCLES(LONG_CYCLES), .SHORT_CYCLES(SHORT_CYCLES)) u_props (.i_clk, .i_reset,
  .i_opt_byte0, .i_opt_byte1, .i_halt_exit, .i_avs_read, .i_avs_write, .o_avs_waitrequest,
  .o_package_select, .o_readout_protect, .o_clock_source_type, .o_oscillator_range,
  .o_reset_delay_select, .o_pullup_lock_grp44, .o_pullup_lock_grp64, .o_extract_block,
  .o_flash_write_block, .o_timer_compare_out1_pin, .o_timer_compare_out2_pin,
  .o_timer_capture_in1_pin, .o_timer_capture_in2_pin, .o_serial2_clock_pin,
  .o_user_erase_req, .o_opt_erase_req, .o_cpu_hold);

// ==== tb.sv ====
// self-checking testbench of the option byte decoder
`timescale 1ns/1ps

module tb;
  import option_byte_pkg::*;
  localparam int LONG_N  = 16;
  localparam int SHORT_N = 4;
  logic               i_clk, i_reset, i_halt_exit, i_user_erase_done, i_opt_erase_done;
  logic               i_avs_read, i_avs_write, o_avs_waitrequest, o_readout_protect;
  logic               o_reset_delay_select, o_pullup_lock_grp44, o_pullup_lock_grp64;
  logic               o_extract_block, o_flash_write_block, o_serial2_enable;
  logic               o_user_erase_req, o_opt_erase_req, o_cpu_hold;
  logic [7:0]         i_opt_byte0, i_opt_byte1, b0, b1;
  logic [3:0]         i_avs_address, i_avs_byteenable;
  logic [31:0]        i_avs_writedata, o_avs_readdata, q, port_w, r, exp;
  package_select_t    o_package_select;
  clock_source_type_t o_clock_source_type;
  oscillator_range_t  o_oscillator_range;
  pin_t               o_timer_compare_out1_pin, o_timer_compare_out2_pin;
  pin_t               o_timer_capture_in1_pin, o_timer_capture_in2_pin;
  pin_t               o_serial2_clock_pin, o_serial2_tx_pin, o_serial2_rx_pin;
  int                 err_count, comparisons, n, nn;

  option_byte_config_decoder #(.LONG_CYCLES(LONG_N), .SHORT_CYCLES(SHORT_N)) u_dut (.i_clk,
    .i_reset, .i_opt_byte0, .i_opt_byte1, .i_halt_exit, .i_user_erase_done, .i_opt_erase_done,
    .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable,
    .o_avs_readdata, .o_avs_waitrequest, .o_package_select, .o_readout_protect,
    .o_clock_source_type, .o_oscillator_range, .o_reset_delay_select, .o_pullup_lock_grp44,
    .o_pullup_lock_grp64, .o_extract_block, .o_flash_write_block, .o_timer_compare_out1_pin,
    .o_timer_compare_out2_pin, .o_timer_capture_in1_pin, .o_timer_capture_in2_pin,
    .o_serial2_clock_pin, .o_serial2_tx_pin, .o_serial2_rx_pin, .o_serial2_enable,
    .o_user_erase_req, .o_opt_erase_req, .o_cpu_hold);

  // decoded outputs laid out as the decode register
  assign port_w = {7'h00, o_serial2_enable, o_timer_capture_in2_pin, o_timer_capture_in1_pin,
    o_timer_compare_out2_pin, o_timer_compare_out1_pin, o_reset_delay_select,
    o_oscillator_range, o_clock_source_type, o_readout_protect, o_package_select};

  always #50 i_clk = ~i_clk;

  function automatic logic [31:0] model(input logic [7:0] a0, input logic [7:0] a1);
    logic [1:0] pk;
    pk = a0[2] ? 2'h2 : {1'b0, a0[1]};
    return {7'h00, a1[7], a1[6] ? 4'h8 : 4'h1, a1[7] ? 4'h7 : 4'h3, a1[7] ? 4'h6 : 4'h4,
      a1[7] ? 4'h5 : 4'h2, a1[0], a1[3:2], a1[5:4], ~a0[0], pk};
  endfunction : model

  task automatic stop_test;
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want)
    begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic wait_until(ref logic s, input logic v, output int cnt);
    cnt = 0;
    while (s !== v && cnt < 300)
    begin
      @(posedge i_clk);
      cnt++;
    end
    if (cnt >= 300)
    begin
      err_count++;
      $display("[FAIL] %0t wait ran out", $time);
      stop_test;
    end
  endtask : wait_until

  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    int k;
    k = 0;
    @(posedge i_clk);
    i_avs_address   <= a;
    i_avs_writedata <= d;
    i_avs_read      <= !wr;
    i_avs_write     <= wr;
    @(posedge i_clk);
    while (o_avs_waitrequest !== 1'b0 && k < 50)
    begin
      @(posedge i_clk);
      k++;
    end
    if (k >= 50)
    begin
      err_count++;
      $display("[FAIL] %0t bus answer missing", $time);
      stop_test;
    end
    rd = o_avs_readdata;
    i_avs_read  <= 1'b0;
    i_avs_write <= 1'b0;
  endtask : bus

  task automatic pulse(input int sel);
    @(posedge i_clk);
    case (sel)
      0:
        i_halt_exit <= 1'b1;
      1:
        i_user_erase_done <= 1'b1;
      default:
        i_opt_erase_done <= 1'b1;
    endcase
    @(posedge i_clk);
    {i_halt_exit, i_user_erase_done, i_opt_erase_done} <= 3'h0;
  endtask : pulse

  initial
  begin
    {i_halt_exit, i_user_erase_done, i_opt_erase_done, i_avs_read, i_avs_write} = 5'h00;
    {i_clk, i_reset, i_avs_address, i_avs_writedata} = {1'b0, 1'b1, 4'h0, 32'h00000000};
    {i_avs_byteenable, i_opt_byte0, i_opt_byte1} = {4'hF, 8'h00, 8'h00};
    err_count   = 0;
    comparisons = 0;
    r = $urandom(32'h442e21cb);
    for (int i = 0; i < 8; i++)
    begin
      r  = $urandom;
      b0 = {r[7:3], i[2:0]};
      b1 = {i[1:0], i[2:1], (i[2:1] == 2'h3) ? 2'h3 : i[1:0], r[0], i[2]};
      nn = b1[0] ? SHORT_N : LONG_N;
      @(posedge i_clk);
      i_reset     <= 1'b1;
      i_opt_byte0 <= b0;
      i_opt_byte1 <= b1;
      repeat (12) @(posedge i_clk);
      i_reset <= 1'b0;
      wait_until(o_cpu_hold, 1'b0, n);
      check(32'(n >= nn && n <= nn + 10), 32'h1);
      exp = model(b0, b1);
      check(port_w, exp);
      check({o_serial2_clock_pin, o_serial2_tx_pin, o_serial2_rx_pin},
        b1[7] ? 12'h243 : 0);
      check({o_pullup_lock_grp44, o_pullup_lock_grp64}, {b0[2:1] == 2'h0, !b0[2]});
      check({o_extract_block, o_flash_write_block}, {2{~b0[0]}});
      bus(1'b0, 4'h4, 0, q);
      check(q, exp);
      bus(1'b0, 4'h0, 0, q);
      check(q, {15'h0000, 1'b1, b1, b0});
      bus(1'b0, i[0] ? 4'h2 : 4'h8, 0, q);
      check(q, 0);
      i_opt_byte0 <= ~b0;
      i_opt_byte1 <= ~b1;
      repeat (6) @(posedge i_clk);
      check(port_w, exp);
      if (i[0])
        bus(1'b1, 4'h8, 32'h00000002, q);
      else
        pulse(0);
      wait_until(o_cpu_hold, 1'b1, n);
      wait_until(o_cpu_hold, 1'b0, n);
      check(32'(n >= nn && n <= nn + 10), 32'h1);
      bus(1'b1, 4'h8, 32'h00000001, q);
      @(posedge i_clk);
      check({o_user_erase_req, o_opt_erase_req}, b0[0] ? 2'b01 : 2'b10);
      if (!b0[0])
      begin
        pulse(1);
        @(posedge i_clk);
        check({o_user_erase_req, o_opt_erase_req}, 2'b01);
      end
      pulse(2);
      repeat (3) @(posedge i_clk);
      check({o_opt_erase_req, o_extract_block, o_flash_write_block}, 0);
      bus(1'b0, 4'hC, 0, q);
      check(q, 32'h00000008);
      $display("test %0d done", i);
    end
    stop_test;
  end
endmodule : tb
